// ===== logic/ccc_map.svh
// Field positions, constants and reset values of the core settings and features registers
//
// Overview of operation
// - ISA type field reads constant 00, read-only
// - ISA revision field reads constant 001
// - MMU type reads build preset, 1 or 3
// - Bits 6:3 read zero; software writes zero
// - Kseg0 attribute writable, resets to uncached 010
// - Code 0 write-through no-allocate; 1 with allocate
// - Code 3 write-back allocate; code 2 uncached
// - Codes 4-6 act as 3; 7 as 2
// - Features bit 31 reads constant one
// - TLB size field reads entries minus one; zero with fixed mapping
// - Icache sets code 0-4 means 64-1024
// - Icache line size 0 absent, 3 sixteen bytes
// - Icache ways code 0-3 means 1-4 ways
// - Dcache sets code 0-4 means 64-1024
// - Dcache line size 0 absent, 3 sixteen bytes
// - Dcache ways code 0-3 means 1-4 ways
// - Coprocessor two bit shows attached coprocessor
// - Media extension bit always reads zero
// - Perf counter bit shows counters are built
// - Watch bit shows watch registers are built
// - Debug unit bit always reads one
// - Float unit bit shows FPU is built
`ifndef CCC_MAP_SVH
`define CCC_MAP_SVH
`define CCC_SET_ISA_TYPE_LSB 13
`define CCC_SET_ISA_REV_LSB 10
`define CCC_SET_MMU_TYPE_LSB 7
`define CCC_SET_ZERO_LSB 3
`define CCC_SET_KSEG0_LSB 0
`define CCC_ISA_TYPE_VAL 2'h0
`define CCC_ISA_REV_VAL 3'h1
`define CCC_MMU_TLB 3'h1
`define CCC_MMU_FIXED 3'h3
`define CCC_KSEG0_RESET 3'h2
`define CCC_TLB_SMALL 16
`define CCC_TLB_LARGE 32
`define CCC_TLB_MAX 64
`define CCC_SETS_MAX 3'h4
`define CCC_WAYS_MAX 3'h3
`define CCC_RDATA_RESET 32'h0000_0000
`define CCC_ATTR_WT_NOALLOC 3'h0
`define CCC_ATTR_WT_ALLOC 3'h1
`define CCC_ATTR_UNCACHED 3'h2
`define CCC_ATTR_WB_ALLOC 3'h3
`define CCC_ATTR_UNUSED_UC 3'h7
`define CCC_LINE_NONE 3'h0
`define CCC_LINE_16B 3'h3
`define CCC_FEAT_NEXT_BIT 31
`define CCC_FEAT_TLB_LSB 25
`define CCC_FEAT_ISETS_LSB 22
`define CCC_FEAT_ILINE_LSB 19
`define CCC_FEAT_IWAYS_LSB 16
`define CCC_FEAT_DSETS_LSB 13
`define CCC_FEAT_DLINE_LSB 10
`define CCC_FEAT_DWAYS_LSB 7
`define CCC_FEAT_COP2_BIT 6
`define CCC_FEAT_MEDIA_BIT 5
`define CCC_FEAT_PERF_BIT 4
`define CCC_FEAT_WATCH_BIT 3
`define CCC_FEAT_COMPRESS_BIT 2
`define CCC_FEAT_DEBUG_BIT 1
`define CCC_FEAT_FLOAT_BIT 0
`define CCC_SEL_SETTINGS 3'h0
`define CCC_SEL_FEATURES 3'h1
`endif

// ===== logic/ccc_pkg.sv
// Types shared by the core capability register bank
package ccc_pkg;
	typedef struct packed {
		logic wr_en;
		logic [2:0] sel;
		logic [31:0] wdata;
	} ccc_req_t;

	typedef struct packed {
		logic cacheable;
		logic write_back;
		logic write_alloc;
	} ccc_attr_t;

	typedef struct packed {
		logic coproc_two_present;
		logic perf_counters_present;
		logic watch_present;
		logic float_unit_present;
	} ccc_straps_t;
endpackage : ccc_pkg

// ===== logic/ccc_regs.sv
// Core settings and features registers with kseg0 cache attribute decode
`timescale 1ns/1ps
`include "ccc_map.svh"
module ccc_regs #(
	parameter logic [2:0] MMU_TYPE = 3'h1,
	parameter int TLB_ENTRIES = 16,
	parameter logic [2:0] ICACHE_SETS = 3'h2,
	parameter bit ICACHE_BUILT = 1'b1,
	parameter logic [2:0] ICACHE_WAYS = 3'h3,
	parameter logic [2:0] DCACHE_SETS = 3'h2,
	parameter bit DCACHE_BUILT = 1'b1,
	parameter logic [2:0] DCACHE_WAYS = 3'h3
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire ccc_pkg::ccc_req_t req,
	input wire ccc_pkg::ccc_straps_t straps,
	output ccc_pkg::ccc_attr_t kseg0_attr,
	output logic [31:0] rdata
);
	import ccc_pkg::*;

	// ************
	// Build checks
	// ************
	// standard or fixed mapping only
	if (MMU_TYPE != `CCC_MMU_TLB && MMU_TYPE != `CCC_MMU_FIXED) begin : g_bad_mmu
		$error("MMU type must be standard or fixed");
	end
	// buffer holds 16 or 32 entries
	if (MMU_TYPE == `CCC_MMU_TLB && TLB_ENTRIES != `CCC_TLB_SMALL
			&& TLB_ENTRIES != `CCC_TLB_LARGE) begin : g_bad_tlb
		$error("TLB must have 16 or 32 entries");
	end
	if (TLB_ENTRIES < 1 || TLB_ENTRIES > `CCC_TLB_MAX) begin : g_bad_tlb_range
		$error("TLB entry count out of range");
	end
	if (ICACHE_SETS > `CCC_SETS_MAX) begin : g_bad_isets
		$error("Instruction sets per way code out of range");
	end
	if (DCACHE_SETS > `CCC_SETS_MAX) begin : g_bad_dsets
		$error("Data sets per way code out of range");
	end
	if (ICACHE_WAYS > `CCC_WAYS_MAX) begin : g_bad_iways
		$error("Instruction ways code out of range");
	end
	if (DCACHE_WAYS > `CCC_WAYS_MAX) begin : g_bad_dways
		$error("Data ways code out of range");
	end
	// Field map kept contiguous
	if (`CCC_FEAT_TLB_LSB + 6 != `CCC_FEAT_NEXT_BIT) begin : g_bad_tlb_pos
		$error("TLB size field overlaps its neighbours");
	end
	if (`CCC_FEAT_ISETS_LSB + 3 != `CCC_FEAT_TLB_LSB) begin : g_bad_isets_pos
		$error("Instruction sets field overlaps its neighbours");
	end
	if (`CCC_FEAT_DSETS_LSB + 3 != `CCC_FEAT_IWAYS_LSB) begin : g_bad_dsets_pos
		$error("Data sets field overlaps its neighbours");
	end
	if (`CCC_FEAT_DLINE_LSB + 3 != `CCC_FEAT_DSETS_LSB) begin : g_bad_dline_pos
		$error("Data line field overlaps its neighbours");
	end
	if (`CCC_FEAT_DWAYS_LSB + 3 != `CCC_FEAT_DLINE_LSB) begin : g_bad_dways_pos
		$error("Data ways field overlaps its neighbours");
	end
	if (`CCC_FEAT_COP2_BIT + 1 != `CCC_FEAT_DWAYS_LSB) begin : g_bad_cop2_pos
		$error("Coprocessor bit overlaps its neighbours");
	end
	if (`CCC_SET_ZERO_LSB + 4 != `CCC_SET_MMU_TYPE_LSB) begin : g_bad_zero_pos
		$error("Zero field overlaps its neighbours");
	end
	if (`CCC_SET_ISA_REV_LSB + 3 != `CCC_SET_ISA_TYPE_LSB) begin : g_bad_rev_pos
		$error("Revision field overlaps its neighbours");
	end

	// ************
	// Helper functions
	// ************
	// unused codes remap
	function automatic logic [2:0] ccc_remap(input logic [2:0] c);
		if (c == `CCC_ATTR_UNUSED_UC) begin
			return `CCC_ATTR_UNCACHED;
		end else if (c > `CCC_ATTR_WB_ALLOC) begin
			return `CCC_ATTR_WB_ALLOC;
		end else begin
			return c;
		end
	endfunction : ccc_remap

	function automatic ccc_attr_t ccc_decode(input logic [2:0] c);
		ccc_attr_t a;
		a = '0;
		unique case (ccc_remap(c))
			`CCC_ATTR_WT_NOALLOC: begin
				a.cacheable = 1'b1;
				a.write_back = 1'b0;
				a.write_alloc = 1'b0;
			end
			`CCC_ATTR_WT_ALLOC: begin
				a.cacheable = 1'b1;
				a.write_back = 1'b0;
				a.write_alloc = 1'b1;
			end
			`CCC_ATTR_UNCACHED: begin
				a.cacheable = 1'b0;
				a.write_back = 1'b0;
				a.write_alloc = 1'b0;
			end
			`CCC_ATTR_WB_ALLOC: begin
				a.cacheable = 1'b1;
				a.write_back = 1'b1;
				a.write_alloc = 1'b1;
			end
		endcase
		return a;
	endfunction : ccc_decode

	function automatic logic ccc_takes_write(input ccc_req_t r);
		return r.wr_en && (r.sel == `CCC_SEL_SETTINGS);
	endfunction : ccc_takes_write

	function automatic logic [2:0] ccc_line_code(input bit built);
		if (built) begin
			return `CCC_LINE_16B;
		end else begin
			return `CCC_LINE_NONE;
		end
	endfunction : ccc_line_code

	// ************
	// Field values
	// ************
	// TLB size field
	localparam logic [5:0] TLB_FIELD =
		(MMU_TYPE == `CCC_MMU_FIXED) ? 6'h00 : 6'(TLB_ENTRIES - 1);

	logic [1:0] isa_type_code;
	logic [2:0] isa_revision_level;
	logic [2:0] mmu_type;
	logic [2:0] kseg0_cache_attr;
	logic [5:0] tlb_entries_minus_one;
	logic [2:0] icache_sets_per_way;
	logic [2:0] icache_line_size;
	logic [2:0] icache_ways;
	logic [2:0] dcache_sets_per_way;
	logic [2:0] dcache_line_size;
	logic [2:0] dcache_ways;
	logic coproc_two_present;
	logic media_ext_present;
	logic perf_counters_present;
	logic watch_present;
	logic compress_present;
	logic debug_unit_present;
	logic float_unit_present;
	logic [2:0] kseg0_code_r;
	ccc_attr_t kseg0_attr_r;
	logic [31:0] settings;
	logic [31:0] features;
	logic [31:0] rdata_nxt;

	// ************
	// Settings fields
	// ************
	// ISA type constant
	assign isa_type_code = `CCC_ISA_TYPE_VAL;
	assign isa_revision_level = `CCC_ISA_REV_VAL;
	assign mmu_type = MMU_TYPE;
	assign kseg0_cache_attr = kseg0_code_r;

	// ************
	// Kseg0 attribute
	// ************
	// writable, reset uncached
	always_ff @(posedge core_clk) begin
		if (srst) begin
			kseg0_code_r <= `CCC_KSEG0_RESET;
		end else if (ccc_takes_write(req)) begin
			kseg0_code_r <= req.wdata[`CCC_SET_KSEG0_LSB +: 3];
		end
	end

	// remapped attribute held in a flop
	always_ff @(posedge core_clk) begin
		if (srst) begin
			kseg0_attr_r <= ccc_decode(`CCC_KSEG0_RESET);
		end else if (ccc_takes_write(req)) begin
			kseg0_attr_r <= ccc_decode(req.wdata[`CCC_SET_KSEG0_LSB +: 3]);
		end
	end

	assign kseg0_attr = kseg0_attr_r;

	// ************
	// Features fields
	// ************
	// TLB size field
	assign tlb_entries_minus_one = TLB_FIELD;
	assign icache_sets_per_way = ICACHE_SETS;
	assign icache_line_size = ccc_line_code(ICACHE_BUILT);
	assign icache_ways = ICACHE_WAYS;
	assign dcache_sets_per_way = DCACHE_SETS;
	assign dcache_line_size = ccc_line_code(DCACHE_BUILT);
	assign dcache_ways = DCACHE_WAYS;
	assign coproc_two_present = straps.coproc_two_present;
	assign media_ext_present = 1'b0;
	assign perf_counters_present = straps.perf_counters_present;
	assign watch_present = straps.watch_present;
	assign compress_present = 1'b0;
	assign debug_unit_present = 1'b1;
	assign float_unit_present = straps.float_unit_present;

	// ************
	// Register images
	// ************
	always_comb begin
		settings = '0;
		settings[`CCC_SET_ISA_TYPE_LSB +: 2] = isa_type_code;
		settings[`CCC_SET_ISA_REV_LSB +: 3] = isa_revision_level;
		settings[`CCC_SET_MMU_TYPE_LSB +: 3] = mmu_type;
		settings[`CCC_SET_ZERO_LSB +: 4] = 4'h0;
		settings[`CCC_SET_KSEG0_LSB +: 3] = kseg0_cache_attr;
	end

	always_comb begin
		features = '0;
		features[`CCC_FEAT_NEXT_BIT] = 1'b1;
		features[`CCC_FEAT_TLB_LSB +: 6] = tlb_entries_minus_one;
		features[`CCC_FEAT_ISETS_LSB +: 3] = icache_sets_per_way;
		features[`CCC_FEAT_ILINE_LSB +: 3] = icache_line_size;
		features[`CCC_FEAT_IWAYS_LSB +: 3] = icache_ways;
		features[`CCC_FEAT_DSETS_LSB +: 3] = dcache_sets_per_way;
		features[`CCC_FEAT_DLINE_LSB +: 3] = dcache_line_size;
		features[`CCC_FEAT_DWAYS_LSB +: 3] = dcache_ways;
		features[`CCC_FEAT_COP2_BIT] = coproc_two_present;
		features[`CCC_FEAT_MEDIA_BIT] = media_ext_present;
		features[`CCC_FEAT_PERF_BIT] = perf_counters_present;
		features[`CCC_FEAT_WATCH_BIT] = watch_present;
		features[`CCC_FEAT_COMPRESS_BIT] = compress_present;
		features[`CCC_FEAT_DEBUG_BIT] = debug_unit_present;
		features[`CCC_FEAT_FLOAT_BIT] = float_unit_present;
	end

	// ************
	// Read port
	// ************
	always_comb begin
		rdata_nxt = `CCC_RDATA_RESET;
		unique case (req.sel)
			`CCC_SEL_SETTINGS: begin
				rdata_nxt = settings;
			end
			`CCC_SEL_FEATURES: begin
				rdata_nxt = features;
			end
			default: begin
				rdata_nxt = `CCC_RDATA_RESET;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rdata <= `CCC_RDATA_RESET;
		end else begin
			rdata <= rdata_nxt;
		end
	end
endmodule : ccc_regs

// ===== test/ccc_regs_sva.sv
// Concurrent checks on the core capability register bank
`timescale 1ns/1ps
module ccc_regs_sva #(parameter logic [2:0] MMU_TYPE = 3'h1) (
	input wire logic core_clk,
	input wire logic srst,
	input wire ccc_pkg::ccc_req_t req,
	input wire ccc_pkg::ccc_straps_t straps,
	input wire ccc_pkg::ccc_attr_t kseg0_attr,
	input wire logic [31:0] rdata
);
	import ccc_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	function automatic logic [2:0] amap(logic [2:0] k);
		case (k)
			3'h0: return 3'h4;
			3'h1: return 3'h5;
			3'h2, 3'h7: return 3'h0;
			default: return 3'h7;
		endcase
	endfunction : amap
	sequence s_wr; req.wr_en && req.sel == 3'h0; endsequence
	sequence s_rd0; req.sel == 3'h0 && !req.wr_en; endsequence
	sequence s_set; !$past(srst) && $past(req.sel) == 3'h0; endsequence
	sequence s_feat; !$past(srst) && $past(req.sel) == 3'h1; endsequence
	property p_type; s_set |-> rdata[14:13] == 2'h0; endproperty
	a_type: assert property (p_type) else $error("type field wrong");
	property p_rev; s_set |-> rdata[12:10] == 3'h1; endproperty
	a_rev: assert property (p_rev) else $error("revision field wrong");
	property p_mmu; s_set |-> rdata[9:7] == MMU_TYPE; endproperty
	a_mmu: assert property (p_mmu) else $error("mmu field wrong");
	property p_zero; s_set |-> rdata[6:3] == 4'h0; endproperty
	a_zero: assert property (p_zero) else $error("zero field set");
	property p_k0; s_wr ##1 s_rd0 |=> rdata[2:0] == $past(req.wdata[2:0], 2); endproperty
	a_k0: assert property (p_k0) else $error("kseg0 readback wrong");
	property p_attr; s_wr |=> kseg0_attr == amap($past(req.wdata[2:0])); endproperty
	a_attr: assert property (p_attr) else $error("attribute decode wrong");
	property p_rst; $fell(srst) |-> kseg0_attr == 3'h0; endproperty
	a_rst: assert property (p_rst) else $error("attribute not uncached");
	property p_fc; s_feat |-> rdata[31] && !rdata[5] && !rdata[2] && rdata[1]; endproperty
	a_fc: assert property (p_fc) else $error("feature constants wrong");
	property p_fs; s_feat |-> {rdata[6], rdata[4:3], rdata[0]} == $past(straps); endproperty
	a_fs: assert property (p_fs) else $error("feature straps wrong");
	property p_ign; req.wr_en && req.sel != 3'h0 |=> $stable(kseg0_attr); endproperty
	a_ign: assert property (p_ign) else $error("ignored write took effect");
endmodule : ccc_regs_sva
bind ccc_regs ccc_regs_sva #(.MMU_TYPE(MMU_TYPE)) u_sva (.core_clk(core_clk), .srst(srst),
	.req(req), .straps(straps), .kseg0_attr(kseg0_attr), .rdata(rdata));

// ===== test/tb_ccc_regs.sv
// Self-checking bench for the core capability register bank
`timescale 1ns/1ps
module tb_ccc_regs;
	import ccc_pkg::*;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	ccc_req_t req = '0;
	ccc_straps_t straps = '0;
	ccc_attr_t kseg0_attr;
	logic [31:0] rdata, exp_rd, r;
	logic [2:0] mk0;
	integer seed = 53, failures = 0, n_checks = 0, cycles = 0, i;
	ccc_regs dut (.core_clk(core_clk), .srst(srst), .req(req), .straps(straps),
		.kseg0_attr(kseg0_attr), .rdata(rdata));
	initial begin
		forever #25 core_clk = ~core_clk;
	end
	function automatic logic [2:0] amap(logic [2:0] k);
		return (k == 3'h0) ? 3'h4 : (k == 3'h1) ? 3'h5 : (k == 3'h2 || k == 3'h7) ? 3'h0 : 3'h7;
	endfunction : amap
	function automatic logic [31:0] image(logic [2:0] s, logic [2:0] k, logic [3:0] st);
		if (s == 3'h0) return {17'h0_0000, 2'h0, 3'h1, 3'h1, 4'h0, k};
		if (s == 3'h1) return {1'b1, 6'h0f, 3'h2, 3'h3, 3'h3, 3'h2, 3'h3, 3'h3,
			st[3], 1'b0, st[2], st[1], 2'h1, st[0]};
		return 32'h0000_0000;
	endfunction : image
	task chk(logic [31:0] seen, logic [31:0] expv);
		n_checks++;
		if (seen !== expv) begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, expv);
		end
	endtask : chk
	task tally_and_finish;
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	task drv(logic w, logic [2:0] s, logic [31:0] d);
		@(posedge core_clk);
		req <= '{w, s, d};
		straps <= r[7:4];
	endtask : drv
	task rnd(integer n);
		repeat (n) begin
			r = $random(seed);
			drv(r[8], r[3] ? r[2:0] : {2'h0, r[0]}, $random(seed));
		end
	endtask : rnd
	// Reference model of the bank
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		exp_rd <= srst ? 32'h0000_0000 : image(req.sel, mk0, straps);
		if (srst)
			mk0 <= 3'h2;
		else if (req.wr_en && req.sel == 3'h0)
			mk0 <= req.wdata[2:0];
		if (cycles == 3000) begin
			failures++;
			tally_and_finish;
		end
	end
	always @(negedge core_clk) begin
		if (cycles > 0) begin
			chk(rdata, exp_rd);
			chk({29'h0, kseg0_attr}, {29'h0, amap(mk0)});
		end
	end
	initial begin
		r = 32'h0000_0000;
		repeat (16) @(posedge core_clk);
		srst <= 1'b0;
		$display("reset test done");
		for (i = 0; i < 8; i++) begin
			r = $random(seed);
			drv(1'b1, 3'h0, {r[31:3], i[2:0]});
			drv(1'b0, 3'h0, r);
			drv(1'b1, 3'h1, ~r);
			drv(1'b1, 3'h5, ~r);
			drv(1'b0, 3'h1, r);
		end
		$display("code test done");
		rnd(400);
		@(posedge core_clk);
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		rnd(200);
		$display("random test done");
		tally_and_finish;
	end
endmodule : tb_ccc_regs
